/* verilog/uvl_pkg.sv */
// package for the undervoltage and open-load fault logic
// assumes one 125 MHz clock and a host register port beside it
`default_nettype none
package uvl_pkg;
    // -------------------------------------------------------------
    // register map (word indices on the plain register port)
    // -------------------------------------------------------------
    localparam logic [3:0] ADDR_STATUS    = 4'h0;
    localparam logic [3:0] ADDR_OUT_CMD   = 4'h1;
    localparam logic [3:0] ADDR_PROTECT   = 4'h2;
    localparam logic [3:0] ADDR_IRQ_STAT  = 4'h3;
    localparam logic [3:0] ADDR_IRQ_EN    = 4'h4;
    localparam logic [3:0] ADDR_IRQ_CLR   = 4'h5;
    localparam logic [3:0] ADDR_LIVE      = 4'h6;
    // -------------------------------------------------------------
    // field positions
    // -------------------------------------------------------------
    localparam int STAT_LOAD_LSB  = 0;   // status [3:0] load missing flags
    localparam int STAT_SUPPLY    = 4;   // status [4] supply low flag
    localparam int PROT_SUPPLY_LOW_PROTECT_DISABLE    = 0;
    localparam int PROT_LOAD_MISSING_DETECT_DISABLE    = 1;
    localparam int IRQ_SUPPLY     = 0;
    localparam int IRQ_LOAD       = 1;
    localparam int IRQ_GND        = 2;
    localparam int NUM_OUT        = 4;
    // -------------------------------------------------------------
    // reset values
    // -------------------------------------------------------------
    localparam logic [3:0] OUT_CMD_RST = 4'h0;
    localparam logic [1:0] PROTECT_RST = 2'h0;
    localparam logic [2:0] IRQ_EN_RST  = 3'h0;
endpackage : uvl_pkg
`default_nettype wire

/* verilog/uvl_fault_logic.sv */
// fault logic for battery undervoltage, open load and ground loss
// assumes comparator inputs are asynchronous and pass a three-stage filter
//
// Contract
// - battery low with protection on: outputs off, fault pin low unless BATTERY_POR is high with all commands off, flag set
// - recovery with all commands off: fault pin returns high by itself
// - recovery with a command on: stays off until commanded off then on
// - supply low flag stays set after recovery until next status read
// - protection disabled: no pin, outputs unchanged, flag still set
// - disabled: flag set while the battery is low and on rising, held until read
// - battery low never resets logic or configuration state
// - serial shifting path works while the battery is absent
// - open load is judged only while the output is off
// - open load flag latched only after gate-off confirmation
// - open load flag clears on status read once the condition is gone
// - open load detection suppressed by its disable bit
// - ground loss forces every output off
// - latched fault pin released once the command is switched off
// - fault register reported on first read, then reset
//
// Decided for this implementation: the register addresses and strobed register access.
`timescale 1ns/1ns
`default_nettype none
module uvl_fault_logic
(
    input  wire logic        CLK,
    input  wire logic        SYS_RST,
    input  wire logic [3:0]  ADDR,
    input  wire logic [7:0]  WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [7:0]  RDATA,
    input  wire logic [3:0]  DIRECT_IN,
    input  wire logic        BATTERY_LOW,
    input  wire logic        BATTERY_POR,
    input  wire logic        GROUND_LOST,
    input  wire logic [3:0]  LOAD_MISSING,
    input  wire logic [3:0]  GATE_OFF,
    input  wire logic        SDI,
    output logic             SDO,
    output logic      [3:0]  OUT_ON,
    output logic             FAULT_INDICATOR_N,
    output logic             IRQ
);
    // -------------------------------------------------------------
    // input filtering: three flops, change taken when 2nd and 3rd agree
    // -------------------------------------------------------------
    localparam int NSYNC = 15;
    logic [NSYNC-1:0] raw;
    logic [NSYNC-1:0] s1_q;
    logic [NSYNC-1:0] s2_q;
    logic [NSYNC-1:0] s3_q;
    logic [NSYNC-1:0] flt_q;
    assign raw = {DIRECT_IN, BATTERY_LOW, BATTERY_POR, GROUND_LOST, LOAD_MISSING, GATE_OFF};

    // synchroniser chain
    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            s1_q  <= '0;
            s2_q  <= '0;
            s3_q  <= '0;
            flt_q <= '0;
        end
        else
        begin
            s1_q  <= raw;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            flt_q <= (s2_q & s3_q) | (flt_q & (s2_q | s3_q));
        end
    end

    logic [3:0] din;
    logic       bat_low;
    logic       bat_por;
    logic       gnd_lost;
    logic [3:0] load_miss;
    logic [3:0] gate_off;
    // filtered views of the pins
    assign din       = flt_q[14:11];
    assign bat_low   = flt_q[10];
    assign bat_por   = flt_q[9];
    assign gnd_lost  = flt_q[8];
    assign load_miss = flt_q[7:4];
    assign gate_off  = flt_q[3:0];

    // -------------------------------------------------------------
    // shared decoding
    // -------------------------------------------------------------
    // strobe aimed at one register index
    function automatic logic reg_hit
    (
        input logic       strobe,
        input logic [3:0] addr,
        input logic [3:0] target
    );
        reg_hit = strobe && (addr == target);
    endfunction : reg_hit

    // next sticky state: a set wins over a write-one clear
    function automatic logic [2:0] irq_next
    (
        input logic [2:0] stat,
        input logic [2:0] set,
        input logic [2:0] clr
    );
        irq_next = set | (stat & ~clr);
    endfunction : irq_next

    // -------------------------------------------------------------
    // registers
    // -------------------------------------------------------------
    logic [3:0] out_cmd_q;
    logic [1:0] protect_q;
    logic [2:0] irq_en_q;
    logic [2:0] irq_stat_q;
    logic [3:0] load_flag_q;
    logic       supply_low_flag_q;
    logic       bat_low_d1_q;
    logic [3:0] uv_latch_q;
    logic [3:0] cmd_d1_q;
    logic       fault_n_q;
    logic [3:0] out_q;
    logic       status_rd;
    logic       supply_low_protect_disable;
    logic       load_missing_detect_disable;
    logic [3:0] cmd;
    logic [3:0] cmd_rise;
    logic       bat_fall;
    logic       bat_rise;
    logic       uv_active;
    logic [3:0] load_event;

    assign supply_low_protect_disable  = protect_q[uvl_pkg::PROT_SUPPLY_LOW_PROTECT_DISABLE];
    assign load_missing_detect_disable = protect_q[uvl_pkg::PROT_LOAD_MISSING_DETECT_DISABLE];
    assign status_rd = reg_hit(RD, ADDR, uvl_pkg::ADDR_STATUS);
    assign cmd       = din | out_cmd_q;
    assign cmd_rise  = cmd & ~cmd_d1_q;
    assign bat_fall  = bat_low & ~bat_low_d1_q;
    assign bat_rise  = ~bat_low & bat_low_d1_q;
    assign uv_active = bat_low & ~supply_low_protect_disable;
    // open load seen only with output off, gate confirmed off, not disabled
    assign load_event = load_miss & ~out_q & gate_off
                      & {4{~load_missing_detect_disable}};

    // -------------------------------------------------------------
    // configuration registers
    // -------------------------------------------------------------
    // per-register write strobes
    logic       wr_out_cmd;
    logic       wr_protect;
    logic       wr_irq_en;
    assign wr_out_cmd = reg_hit(WR, ADDR, uvl_pkg::ADDR_OUT_CMD);
    assign wr_protect = reg_hit(WR, ADDR, uvl_pkg::ADDR_PROTECT);
    assign wr_irq_en  = reg_hit(WR, ADDR, uvl_pkg::ADDR_IRQ_EN);

    // output command; only reset or a register write clears it, never battery state
    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
            out_cmd_q <= uvl_pkg::OUT_CMD_RST;
        else if (wr_out_cmd)
            out_cmd_q <= WDATA[3:0];
    end

    // protection disable bits, kept through battery loss
    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
            protect_q <= uvl_pkg::PROTECT_RST;
        else if (wr_protect)
            protect_q <= WDATA[1:0];
    end

    // interrupt enable bits
    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
            irq_en_q <= uvl_pkg::IRQ_EN_RST;
        else if (wr_irq_en)
            irq_en_q <= WDATA[2:0];
    end

    // -------------------------------------------------------------
    // edge detection
    // -------------------------------------------------------------
    // battery level one clock back
    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
            bat_low_d1_q <= 1'b0;
        else
            bat_low_d1_q <= bat_low;
    end

    // command one clock back, for switch-on detection
    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
            cmd_d1_q <= 4'h0;
        else
            cmd_d1_q <= cmd;
    end

    // -------------------------------------------------------------
    // fault flags
    // -------------------------------------------------------------
    // supply low flag: set wins over read clear
    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
            supply_low_flag_q <= 1'b0;
        else if (uv_active || (supply_low_protect_disable && (bat_rise || bat_low)))
            supply_low_flag_q <= 1'b1;
        else if (status_rd)
            supply_low_flag_q <= 1'b0;
    end

    // open load flags: cleared on read only when the condition is gone
    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
            load_flag_q <= 4'h0;
        else if (status_rd)
            load_flag_q <= load_event;
        else
            load_flag_q <= load_flag_q | load_event;
    end

    // -------------------------------------------------------------
    // output control
    // -------------------------------------------------------------
    // undervoltage latch per output: held until the command goes off
    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
            uv_latch_q <= 4'h0;
        else if (uv_active)
            uv_latch_q <= cmd;
        else
            uv_latch_q <= uv_latch_q & cmd & ~cmd_rise;
    end

    // output drive
    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
            out_q <= 4'h0;
        else if (gnd_lost)
            out_q <= 4'h0;
        else if (uv_active)
            out_q <= 4'h0;
        else
            out_q <= cmd & ~uv_latch_q;
    end

    // fault pin: low during active undervoltage while BATTERY_POR is low, latched outputs or open load
    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
            fault_n_q <= 1'b1;
        else
            fault_n_q <= ~((uv_active && !bat_por) || (|uv_latch_q) || (|load_event));
    end

    // -------------------------------------------------------------
    // interrupts: sticky status, write-one clear, set wins
    // -------------------------------------------------------------
    logic [2:0] irq_set;
    logic [2:0] irq_clr;
    assign irq_set = {gnd_lost, |load_event, bat_fall};
    assign irq_clr = reg_hit(WR, ADDR, uvl_pkg::ADDR_IRQ_CLR) ? WDATA[2:0] : 3'h0;

    // sticky event bits
    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
            irq_stat_q <= 3'h0;
        else
            irq_stat_q <= irq_next(irq_stat_q, irq_set, irq_clr);
    end

    // level interrupt from the same next state, no extra clock of lag
    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
            IRQ <= 1'b0;
        else
            IRQ <= |(irq_next(irq_stat_q, irq_set, irq_clr) & irq_en_q);
    end

    // -------------------------------------------------------------
    // read port, data one cycle after the strobe
    // -------------------------------------------------------------
    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
            RDATA <= 8'h00;
        else if (RD)
        begin
            case (ADDR)
                uvl_pkg::ADDR_STATUS:   RDATA <= {3'h0, supply_low_flag_q, load_flag_q};
                uvl_pkg::ADDR_OUT_CMD:  RDATA <= {4'h0, out_cmd_q};
                uvl_pkg::ADDR_PROTECT:  RDATA <= {6'h00, protect_q};
                uvl_pkg::ADDR_IRQ_STAT: RDATA <= {5'h00, irq_stat_q};
                uvl_pkg::ADDR_IRQ_EN:   RDATA <= {5'h00, irq_en_q};
                uvl_pkg::ADDR_LIVE:     RDATA <= {out_q, bat_low, gnd_lost, 1'b0, fault_n_q};
                default:                RDATA <= 8'h00;
            endcase
        end
        else
            RDATA <= 8'h00;
    end

    // -------------------------------------------------------------
    // pin registers
    // -------------------------------------------------------------
    // daisy chain pass, independent of battery state
    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
            SDO <= 1'b0;
        else
            SDO <= SDI;
    end

    // output drive pins
    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
            OUT_ON <= 4'h0;
        else
            OUT_ON <= out_q;
    end

    // fault pin, idle high
    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
            FAULT_INDICATOR_N <= 1'b1;
        else
            FAULT_INDICATOR_N <= fault_n_q;
    end
endmodule : uvl_fault_logic
`default_nettype wire

/* test/uvl_fault_logic_chk.sv */
// port checker for the fault logic
// assumes it is bound onto uvl_fault_logic
`timescale 1ns/1ns
`default_nettype none
module uvl_chk
(
    input wire logic       CLK,
    input wire logic       SYS_RST,
    input wire logic [3:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic       WR,
    input wire logic       RD,
    input wire logic [7:0] RDATA,
    input wire logic       SDI,
    input wire logic       SDO,
    input wire logic [3:0] OUT_ON,
    input wire logic       FAULT_INDICATOR_N,
    input wire logic       IRQ,
    input wire logic       BATTERY_LOW,
    input wire logic       BATTERY_POR,
    input wire logic       GROUND_LOST
);
    logic       dis_q;
    logic [2:0] en_q;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    // ---------------------------------------------
    // shadow of protect and irq enable writes
    // ---------------------------------------------
    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            dis_q <= 1'b0;
            en_q  <= 3'h0;
        end
        else if (WR)
        begin
            if (ADDR == uvl_pkg::ADDR_PROTECT) dis_q <= WDATA[uvl_pkg::PROT_SUPPLY_LOW_PROTECT_DISABLE];
            if (ADDR == uvl_pkg::ADDR_IRQ_EN) en_q <= WDATA[2:0];
        end
    end
    // ---------------------------------------------
    // assertions
    // ---------------------------------------------
    a_gnd_off: assert property (GROUND_LOST [*8] |-> OUT_ON == 4'h0)
        else $error("outputs on during ground loss");
    a_uv_off: assert property ((BATTERY_LOW && !dis_q) [*8] |-> OUT_ON == 4'h0)
        else $error("outputs on during battery low");
    a_uv_pin: assert property ((BATTERY_LOW && !BATTERY_POR && !dis_q) [*8]
        |-> !FAULT_INDICATOR_N)
        else $error("fault pin high during battery low");
    a_sdo_pass: assert property (!$past(SYS_RST) |-> SDO == $past(SDI))
        else $error("chain output not one clock behind");
    a_rd_idle: assert property (!$past(RD) |-> RDATA == 8'h00)
        else $error("read data outside read slot");
    a_rd_unmap: assert property (RD && ADDR > 4'h6 |=> RDATA == 8'h00)
        else $error("unmapped read not zero");
    a_irq_mask: assert property (en_q == 3'h0 && $past(en_q) == 3'h0 |-> !IRQ)
        else $error("interrupt with all sources masked");
    a_uv_flag: assert property (BATTERY_LOW [*8]
        ##0 (RD && ADDR == uvl_pkg::ADDR_STATUS) |=> RDATA[uvl_pkg::STAT_SUPPLY])
        else $error("supply low flag not reported");
    c_uv: cover property (BATTERY_LOW [*8]);
    c_gnd: cover property (GROUND_LOST [*8]);
    c_irq: cover property ($rose(IRQ));
endmodule : uvl_chk
bind uvl_fault_logic uvl_chk uvl_chk_i (.CLK(CLK), .SYS_RST(SYS_RST), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .SDI(SDI), .SDO(SDO), .OUT_ON(OUT_ON),
    .FAULT_INDICATOR_N(FAULT_INDICATOR_N), .IRQ(IRQ), .BATTERY_LOW(BATTERY_LOW),
    .BATTERY_POR(BATTERY_POR), .GROUND_LOST(GROUND_LOST));
`default_nettype wire

/* test/uvl_gate_model.sv */
// gate stage model: confirms off two clocks after the drive drops
// assumes the clock and reset of the fault logic
`timescale 1ns/1ns
`default_nettype none
module uvl_gate_model
(
    input wire logic       CLK,
    input wire logic       SYS_RST,
    input wire logic [3:0] OUT_ON,
    output var logic [3:0] GATE_OFF
);
    logic [3:0] mid_q;
    // two-stage gate discharge
    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            mid_q    <= 4'hF;
            GATE_OFF <= 4'hF;
        end
        else
        begin
            mid_q    <= ~OUT_ON;
            GATE_OFF <= mid_q;
        end
    end
endmodule : uvl_gate_model
`default_nettype wire

/* test/uvl_fault_logic_tb_top.sv */
// self-checking bench for the fault logic
// assumes the gate model and the bound checker
`timescale 1ns/1ns
`default_nettype none
module uvl_fault_logic_tb_top;
    logic       clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, rd_p = 1'b0, sdi = 1'b0;
    logic       bat = 1'b0, por = 1'b0, gnd = 1'b0, sdo, fault_n, irq;
    logic       rst_p = 1'b1, sdi_p = 1'b0;
    logic [3:0] addr = 4'h0, din = 4'h0, load = 4'h0, gate, out_on;
    logic [7:0] wdata = 8'h00, rdata, r;
    logic [7:0] exp_q[$];
    int         error_cnt = 0, num_checks = 0, cyc = 0;
    always #4 clk = ~clk;
    uvl_fault_logic uvl_fault_logic_i (.CLK(clk), .SYS_RST(rst), .ADDR(addr), .WDATA(wdata),
        .WR(wr), .RD(rd), .RDATA(rdata), .DIRECT_IN(din), .BATTERY_LOW(bat),
        .BATTERY_POR(por), .GROUND_LOST(gnd), .LOAD_MISSING(load), .GATE_OFF(gate),
        .SDI(sdi), .SDO(sdo), .OUT_ON(out_on), .FAULT_INDICATOR_N(fault_n), .IRQ(irq));
    uvl_gate_model uvl_gate_model_i (.CLK(clk), .SYS_RST(rst), .OUT_ON(out_on),
        .GATE_OFF(gate));
    // ---------------------------------------------
    // tasks
    // ---------------------------------------------
    task automatic results;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : results
    task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask : cmp
    // one bus cycle, a read notes its expected data
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= w;
        rd    <= !w;
        if (!w) exp_q.push_back(d);
        @(posedge clk);
        wr    <= 1'b0;
        rd    <= 1'b0;
    endtask : bus
    // let the input filter settle, then look at the pins
    task automatic settle(input logic [3:0] eo, input logic ef);
        repeat (10) @(posedge clk);
        @(negedge clk);
        cmp("OUT_ON", {4'h0, eo}, {4'h0, out_on});
        cmp("FAULT_N", {7'h00, ef}, {7'h00, fault_n});
        @(posedge clk);
    endtask : settle
    // ---------------------------------------------
    // read data monitor, timeout, chain stimulus
    // ---------------------------------------------
    always @(posedge clk)
    begin
        rd_p  <= rd;
        rst_p <= rst;
        sdi_p <= sdi;
    end
    always @(negedge clk)
    begin
        if (rd_p) cmp("RDATA", exp_q.pop_front(), rdata);
        if (!rst_p) cmp("SDO", {7'h00, sdi_p}, {7'h00, sdo});
    end
    always @(posedge clk) sdi <= 1'($urandom);
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            error_cnt++;
            results();
        end
    end
    // ---------------------------------------------
    // main sequence
    // ---------------------------------------------
    initial
    begin
        void'($urandom(60));
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        bus(0, uvl_pkg::ADDR_OUT_CMD, 8'h00);
        bus(0, uvl_pkg::ADDR_PROTECT, 8'h00);
        bus(0, 4'hF, 8'h00);
        settle(4'h0, 1'b1);
        repeat (3)
        begin
            r = 8'($urandom);
            bus(1, uvl_pkg::ADDR_OUT_CMD, {4'h0, r[3:0]});
            din <= r[7:4];
            bus(0, uvl_pkg::ADDR_OUT_CMD, {4'h0, r[3:0]});
            settle(r[3:0] | r[7:4], 1'b1);
        end
        bus(1, uvl_pkg::ADDR_OUT_CMD, 8'h00);
        din <= 4'h0;
        bat <= 1'b1;
        settle(4'h0, 1'b0);
        por <= 1'b1;
        settle(4'h0, 1'b1);
        por <= 1'b0;
        bat <= 1'b0;
        settle(4'h0, 1'b1);
        bus(0, uvl_pkg::ADDR_STATUS, 8'h10);
        bus(0, uvl_pkg::ADDR_STATUS, 8'h00);
        bus(1, uvl_pkg::ADDR_IRQ_EN, {5'h00, r[2:0]});
        din <= 4'h1;
        settle(4'h1, 1'b1);
        bat <= 1'b1;
        settle(4'h0, 1'b0);
        bat <= 1'b0;
        settle(4'h0, 1'b0);
        bus(0, uvl_pkg::ADDR_IRQ_EN, {5'h00, r[2:0]});
        din <= 4'h0;
        repeat (10) @(posedge clk);
        din <= 4'h1;
        settle(4'h1, 1'b1);
        bus(0, uvl_pkg::ADDR_STATUS, 8'h10);
        bus(1, uvl_pkg::ADDR_PROTECT, 8'h01);
        bat <= 1'b1;
        settle(4'h1, 1'b1);
        bus(0, uvl_pkg::ADDR_STATUS, 8'h10);
        bat <= 1'b0;
        din <= 4'h0;
        settle(4'h0, 1'b1);
        bus(0, uvl_pkg::ADDR_STATUS, 8'h10);
        bus(0, uvl_pkg::ADDR_STATUS, 8'h00);
        bus(1, uvl_pkg::ADDR_PROTECT, 8'h00);
        bus(1, uvl_pkg::ADDR_IRQ_CLR, 8'h07);
        bus(1, uvl_pkg::ADDR_IRQ_EN, 8'h02);
        din  <= 4'h2;
        repeat (10) @(posedge clk);
        load <= 4'h6;
        settle(4'h2, 1'b0);
        bus(0, uvl_pkg::ADDR_STATUS, 8'h04);
        @(negedge clk);
        cmp("IRQ", 8'h01, {7'h00, irq});
        @(posedge clk);
        din  <= 4'h0;
        load <= 4'h0;
        settle(4'h0, 1'b1);
        bus(0, uvl_pkg::ADDR_STATUS, 8'h04);
        bus(0, uvl_pkg::ADDR_STATUS, 8'h00);
        bus(1, uvl_pkg::ADDR_IRQ_EN, 8'h00);
        bus(0, uvl_pkg::ADDR_IRQ_STAT, 8'h02);
        @(negedge clk);
        cmp("IRQ", 8'h00, {7'h00, irq});
        @(posedge clk);
        bus(1, uvl_pkg::ADDR_IRQ_CLR, 8'h07);
        bus(0, uvl_pkg::ADDR_IRQ_STAT, 8'h00);
        bus(1, uvl_pkg::ADDR_PROTECT, 8'h02);
        load <= 4'hF;
        settle(4'h0, 1'b1);
        bus(0, uvl_pkg::ADDR_STATUS, 8'h00);
        load <= 4'h0;
        din  <= 4'hF;
        gnd  <= 1'b1;
        repeat (10) @(posedge clk);
        @(negedge clk);
        cmp("OUT_ON", 8'h00, {4'h0, out_on});
        results();
    end
endmodule : uvl_fault_logic_tb_top
`default_nettype wire
